// ### rtl/cs_unit_pkg.sv
// Purpose: Shared constants for the chip-select and wait-state unit
// Assumes: One 25 MHz clock; configuration arrives as plain ports
// Notes: Wait codes 0..13 insert states, 14 is fast, 15 waits externally
package cs_unit_pkg;
  localparam int NUM_CS = 12;
  localparam int ADDR_W_DEF = 24;
  localparam int BOOT_CH = 0;
  // Per-channel wait code encodings
  localparam logic [3:0] WAIT_MAX = 4'hD;
  localparam logic [3:0] WAIT_FAST = 4'hE;
  localparam logic [3:0] WAIT_EXT = 4'hF;
  localparam logic [3:0] BOOT_WAIT_RST = 4'hD;
  // Cycle lengths in clocks
  localparam logic [4:0] BASE_CLOCKS = 5'h03;
  localparam logic [4:0] FAST_CLOCKS = 5'h02;
  localparam logic [3:0] EXT_FIRST_PHASE = 4'h2;
  localparam logic [3:0] DS_WRITE_PHASE = 4'h1;
  localparam logic [3:0] PHASE_SAT = 4'hF;
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // Sync holds only post-release samples by then
  // Channel function codes
  localparam logic [1:0] FUNC_SEL = 2'h0;
  localparam logic [1:0] FUNC_INTERRUPT_ACK_STROBE = 2'h1;
  localparam logic [1:0] FUNC_AUTOVECTOR_TERMINATION = 2'h2;
  // Byte-lane decode and direction codes
  localparam logic [1:0] BYTE_BOTH = 2'h0;
  localparam logic [1:0] BYTE_UPPER = 2'h1;
  localparam logic [1:0] BYTE_LOWER = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h0;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
endpackage

// ### rtl/cs_match.sv
// Purpose: Address, space, direction and byte-lane decode of one channel
// Assumes: Inputs come from registered cycle state on the same clock
// Notes: Purely combinational; the parent registers the cycle state but drives select_n straight from line
`timescale 1ns/1ps
module cs_match import cs_unit_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic [ADDR_W-1:0] addr, // Latched cycle address
  input wire logic [ADDR_W-1:0] base, // Channel base address
  input wire logic [ADDR_W-1:0] mask, // Ones mark compared bits
  input wire logic enable, // Channel enabled
  input wire logic cpu_space, // Cycle is an interrupt acknowledge
  input wire logic rd, // Cycle reads
  input wire logic word, // Cycle moves a word
  input wire logic [1:0] func, // Channel function
  input wire logic port16, // Target is 16 bits wide
  input wire logic [1:0] byte_mode, // Byte-lane decode
  input wire logic [1:0] rw_mode, // Direction qualifier
  input wire logic whole_word, // Ignore byte decode entirely
  output logic hit, // Range and space match
  output logic line // Select line may assert
);
  logic space_ok;
  logic lane_hi;
  logic lane_lo;
  logic lane_ok;
  logic dir_ok;

  // Acknowledge functions only answer cycles in cpu space
  assign space_ok = (func == FUNC_SEL) ? !cpu_space : cpu_space;
  assign hit = enable && space_ok && (((addr ^ base) & mask) == '0);
  // Even byte rides the upper lane, odd byte the lower one
  assign lane_hi = !port16 || word || !addr[0];
  assign lane_lo = port16 && (word || addr[0]);
  // Lane decode only has meaning on a 16-bit port
  always_comb begin
    lane_ok = 1'b1;
    if (port16 && !whole_word && byte_mode == BYTE_UPPER) begin
      lane_ok = lane_hi;
    end else if (port16 && !whole_word && byte_mode == BYTE_LOWER) begin
      lane_ok = lane_lo;
    end
  end
  assign dir_ok = (rw_mode == RW_BOTH) || ((rw_mode == RW_READ) == rd);
  assign line = hit && lane_ok && dir_ok;
endmodule

// ### rtl/chip_select_wait_state_unit.sv
// Purpose: Twelve chip selects with internal or external cycle termination
// Assumes: Pin inputs are raw and get two flops; requests are clk-domain
// Notes: Channel 0 is the boot select; read data is sampled after sync
// Operation
// - Twelve independent select outputs, each asserted for its programmed range.
// - A channel may select, acknowledge, strobe interrupt acknowledge or autovector.
// - A channel waits for external acknowledge inputs or terminates internally.
// - Internal termination works even when the pin serves another use.
// - Programmed wait states are inserted after state 3, then the cycle ends.
// - Internally ended cycle lasts three clocks plus one per wait state.
// - Wait count reaches at most thirteen.
// - Fast option ends the cycle one clock before zero wait.
// - Select timed from address strobe or data strobe; data strobe later on writes.
// - Boot channel is enabled straight out of reset.
// - Boot width latched from lowest data line at reset release; default 16.
// - Writes through the 16-bit boot select always cover the whole word.
// - Each channel is an 8-bit or 16-bit port; transfers sized to fit.
// - An 8-bit port moves data only on the upper eight lines.
// - Writes to an 8-bit port echo the byte on the lower lines.
// - Byte reads from a 16-bit port take only the addressed lane.
// - A 16-bit channel other than the boot channel may decode only upper or only lower byte accesses.
`timescale 1ns/1ps
module chip_select_wait_state_unit import cs_unit_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic cyc_start, // Pulse: start a bus cycle
  input wire logic [ADDR_W-1:0] cyc_addr, // Byte address of the cycle
  input wire logic cyc_read, // High for read
  input wire logic cyc_word, // High for word, low for byte
  input wire logic cyc_cpu_space, // Interrupt acknowledge cycle
  input wire logic [15:0] cyc_wdata, // Write data, byte in low half
  output logic cyc_done, // Pulse: cycle finished
  output logic cyc_autovec, // Pulse with done: autovector ending
  output logic [15:0] cyc_rdata, // Read data, byte in low half
  input wire logic [NUM_CS*ADDR_W-1:0] cs_base, // Base per channel
  input wire logic [NUM_CS*ADDR_W-1:0] cs_mask, // Compare mask per channel
  input wire logic [NUM_CS-1:0] cs_enable, // Channel enables
  input wire logic [NUM_CS-1:0] cs_pin_sel, // Pin used as select
  input wire logic [2*NUM_CS-1:0] cs_func, // Function per channel
  input wire logic [4*NUM_CS-1:0] cs_wait, // Wait code per channel
  input wire logic [NUM_CS-1:0] cs_port16, // 16-bit port per channel
  input wire logic [2*NUM_CS-1:0] cs_byte, // Byte decode per channel
  input wire logic [2*NUM_CS-1:0] cs_rw, // Direction per channel
  input wire logic [NUM_CS-1:0] cs_use_ds, // Time from data strobe
  input wire logic boot_program, // Software took over boot channel
  output logic [NUM_CS-1:0] select_n, // Select pins, active low
  output logic interrupt_ack_strobe, // Acknowledge strobe active
  output logic [ADDR_W-1:0] bus_addr, // External address
  output logic bus_read, // External read/write level
  output logic as_n, // Address strobe, active low
  output logic ds_n, // Data strobe, active low
  output logic [15:0] data_out, // Data pins, output value
  output logic data_oe, // Data pins driven
  input wire logic [15:0] data_in, // Data pins, input value
  input wire logic width_strap_line, // Lowest data line at reset
  input wire logic transfer_size_ack_high_n, // External ack, upper
  input wire logic transfer_size_ack_low_n, // External ack, lower
  output logic boot_port16 // Latched boot width
);
  typedef enum logic [0:0] {CYC_IDLE, CYC_RUN} cyc_e;
  typedef struct packed {
    cyc_e st;
    logic [3:0] phase;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic word;
    logic cpu;
    logic second;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] dout;
    logic done;
    logic autovector_termination;
    logic [1:0] ackh_s;
    logic [1:0] ackl_s;
    logic [1:0] strap_s;
    logic [1:0] strap_age;
    logic strap16;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
  } state_s;

  state_s st;
  state_s next_st;
  logic [NUM_CS-1:0] hit;
  logic [NUM_CS-1:0] line;
  logic [NUM_CS-1:0] ds_ok;
  logic [NUM_CS-1:0] is_interrupt_ack_strobe;
  logic [3:0] ch;
  logic any_hit;
  logic [3:0] ws;
  logic port16;
  logic ext_ack;
  logic [4:0] len;
  logic last_int;
  logic ack_seen;
  logic term;
  logic split;

  // Per-channel decode; boot channel runs on reset defaults until programmed
  for (genvar i = 0; i < NUM_CS; i++) begin : g_ch
    logic boot_dflt;
    logic en;
    logic p16;
    logic [1:0] fn;
    assign boot_dflt = (i == BOOT_CH) && !boot_program;
    assign en = boot_dflt ? 1'b1 : cs_enable[i];
    assign p16 = (i == BOOT_CH) && !boot_program ? st.strap16 : cs_port16[i];
    assign fn = boot_dflt ? FUNC_SEL : cs_func[2*i +: 2];
    cs_match #(.ADDR_W(ADDR_W)) u_match (
      .addr(st.addr),
      .base(cs_base[ADDR_W*i +: ADDR_W]),
      .mask(boot_dflt ? '0 : cs_mask[ADDR_W*i +: ADDR_W]),
      .enable(en),
      .cpu_space(st.cpu),
      .rd(st.rd),
      .word(st.word),
      .func(fn),
      .port16(p16),
      .byte_mode(boot_dflt ? BYTE_BOTH : cs_byte[2*i +: 2]),
      .rw_mode(boot_dflt ? RW_BOTH : cs_rw[2*i +: 2]),
      .whole_word((i == BOOT_CH) && p16),
      .hit(hit[i]),
      .line(line[i])
    );
    // Data-strobe timing holds write selects off in the first state
    assign ds_ok[i] = !(cs_use_ds[i] && !boot_dflt && !st.rd)
      || (st.phase >= DS_WRITE_PHASE);
    // Pin given to another use stays high, yet termination still comes
    assign select_n[i] = !(st.st == CYC_RUN && line[i] && ds_ok[i]
      && (cs_pin_sel[i] || boot_dflt));
    assign is_interrupt_ack_strobe[i] = (fn == FUNC_INTERRUPT_ACK_STROBE) && !select_n[i];
  end

  assign interrupt_ack_strobe = |is_interrupt_ack_strobe;

  // Lowest matching channel owns termination and port width
  always_comb begin
    ch = 4'h0;
    any_hit = 1'b0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        ch = 4'(i);
        any_hit = 1'b1;
      end
    end
  end

  assign ws = (ch == 4'(BOOT_CH) && !boot_program) ? BOOT_WAIT_RST : cs_wait[4*ch +: 4];
  assign port16 = (ch == 4'(BOOT_CH) && !boot_program) ? st.strap16 : cs_port16[ch];
  assign ext_ack = !any_hit || ws == WAIT_EXT;
  // Three base clocks plus waits, or two for fast ending
  assign len = (ws == WAIT_FAST) ? FAST_CLOCKS : BASE_CLOCKS + {1'b0, ws};
  assign last_int = !ext_ack && ({1'b0, st.phase} == len - 5'h01);
  assign ack_seen = !st.ackh_s[1] || !st.ackl_s[1];
  assign term = (st.st == CYC_RUN)
    && (last_int || (ext_ack && st.phase >= EXT_FIRST_PHASE && ack_seen));
  // A word through an 8-bit port is split into two byte cycles
  assign split = st.word && !port16;

  // Pin driven outputs; data held back until it is settled in state two
  assign bus_addr = st.addr;
  assign bus_read = (st.st == CYC_RUN) ? st.rd : 1'b1;
  assign as_n = !(st.st == CYC_RUN);
  assign ds_n = !(st.st == CYC_RUN && (st.rd || st.phase >= DS_WRITE_PHASE));
  assign data_out = st.dout;
  assign data_oe = st.st == CYC_RUN && !st.rd && st.phase >= DS_WRITE_PHASE;
  assign cyc_done = st.done;
  assign cyc_autovec = st.autovector_termination;
  assign cyc_rdata = st.rdata;
  assign boot_port16 = st.strap16;

  // Next-state logic of the whole unit
  always_comb begin
    logic [7:0] wb;
    next_st = st;
    wb = st.wdata[7:0];
    next_st.done = 1'b0;
    next_st.autovector_termination = 1'b0;
    next_st.ackh_s = {st.ackh_s[0], transfer_size_ack_high_n};
    next_st.ackl_s = {st.ackl_s[0], transfer_size_ack_low_n};
    next_st.strap_s = {st.strap_s[0], width_strap_line};
    next_st.din_s1 = data_in;
    next_st.din_s2 = st.din_s1;
    // Width strap taken once the synchroniser has filled after release
    if (st.strap_age != STRAP_SETTLE) begin
      next_st.strap_age = st.strap_age + 2'h1;
      if (st.strap_age + 2'h1 == STRAP_SETTLE) begin
        next_st.strap16 = st.strap_s[1];
      end
    end
    // Write lanes: 8-bit byte on upper with echo, 16-bit byte on both lanes, except the boot channel's whole word
    if (split) begin
      wb = st.second ? st.wdata[7:0] : st.wdata[15:8];
    end
    if (!port16) begin
      next_st.dout = {wb, wb};
    end else if (st.word || (ch == 4'(BOOT_CH))) begin
      next_st.dout = st.wdata;
    end else begin
      next_st.dout = {wb, wb};
    end
    case (st.st)
      CYC_IDLE: begin
        if (cyc_start) begin
          next_st.st = CYC_RUN;
          next_st.phase = 4'h0;
          next_st.addr = cyc_addr;
          next_st.rd = cyc_read;
          next_st.word = cyc_word;
          next_st.cpu = cyc_cpu_space;
          next_st.wdata = cyc_wdata;
          next_st.second = 1'b0;
        end
      end
      CYC_RUN: begin
        if (term) begin
          if (st.rd) begin
            if (!port16) begin
              // 8-bit port reads only the upper lines
              if (!st.word) begin
                next_st.rdata = {8'h00, st.din_s2[15:8]};
              end else if (st.second) begin
                next_st.rdata[7:0] = st.din_s2[15:8];
              end else begin
                next_st.rdata[15:8] = st.din_s2[15:8];
              end
            end else if (st.word) begin
              next_st.rdata = st.din_s2;
            end else begin
              // Other lane is ignored on a byte read
              next_st.rdata = {8'h00, st.addr[0] ? st.din_s2[7:0] : st.din_s2[15:8]};
            end
          end
          if (split && !st.second) begin
            next_st.second = 1'b1;
            next_st.addr[0] = 1'b1;
            next_st.phase = 4'h0;
          end else begin
            next_st.st = CYC_IDLE;
            next_st.done = 1'b1;
            next_st.autovector_termination = any_hit && cs_func[2*ch +: 2] == FUNC_AUTOVECTOR_TERMINATION
              && !(ch == 4'(BOOT_CH) && !boot_program);
          end
        end else if (st.phase != PHASE_SAT) begin
          next_st.phase = st.phase + 4'h1;
        end
      end
      default: next_st.st = CYC_IDLE;
    endcase
  end

  // State register; strap sync resets high to match the weak pull-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.st <= CYC_IDLE;
      st.rd <= 1'b1;
      st.ackh_s <= 2'h3;
      st.ackl_s <= 2'h3;
      st.strap_s <= 2'h3;
      st.strap16 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Helper for checks: clocks spent in the current half-cycle
  logic [4:0] run_clocks;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_clocks <= 5'h00;
    end else if (st.st != CYC_RUN || term) begin
      run_clocks <= 5'h00;
    end else if (run_clocks != 5'h1F) begin
      run_clocks <= run_clocks + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence int_end_s;
    term && !ext_ack;
  endsequence
  sequence fast_end_s;
    term && !ext_ack && ws == WAIT_FAST;
  endsequence

  cycle_length_a: assert property (
    int_end_s |-> (run_clocks + 5'h01 == BASE_CLOCKS + {1'b0, ws}) || ws == WAIT_FAST)
    else $error("internal cycle length wrong");
  fast_length_a: assert property (
    fast_end_s |-> run_clocks == 5'h01)
    else $error("fast cycle not two clocks");
  wait_bound_a: assert property (
    (st.st == CYC_RUN && !ext_ack) |-> run_clocks < BASE_CLOCKS + {1'b0, WAIT_MAX})
    else $error("wait states exceed limit");
  ext_hold_a: assert property (
    (st.st == CYC_RUN && ext_ack && st.ackh_s[1] && st.ackl_s[1]) |=> !cyc_done)
    else $error("cycle ended without external ack");
  echo_lanes_a: assert property (
    (data_oe && !port16) |-> data_out[7:0] == data_out[15:8])
    else $error("8-bit write not echoed");
  byte_read_a: assert property (
    (term && st.rd && !port16 && !st.word) |=> cyc_rdata == {8'h00, $past(st.din_s2[15:8])})
    else $error("8-bit read not on upper lane");
  ds_write_a: assert property (
    (st.st == CYC_RUN && st.phase == 4'h0 && !st.rd && cs_use_ds[ch] && boot_program)
    |-> select_n[ch])
    else $error("data-strobe select too early");
  boot_live_a: assert property (
    (!boot_program && st.st == CYC_IDLE && cyc_start && !cyc_cpu_space) |=> !select_n[BOOT_CH])
    else $error("boot select not active");
  done_pulse_a: assert property (
    cyc_done |=> !cyc_done)
    else $error("done longer than one clock");
  read_only_a: assert property (
    (st.st == CYC_RUN && !st.rd && cs_rw[2*ch +: 2] == RW_READ && boot_program && any_hit)
    |-> select_n[ch])
    else $error("read-only select on write");
endmodule

// ### verification/ext_mem_model.sv
// Purpose: External memory and peripheral stand-in for the chip-select unit
// Assumes: Fixed byte pattern as contents; ack lines have pull-ups
// Notes: Released data lines show the inverse of their last value
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk, // System clock
  input wire logic as_n, // Address strobe, active low
  input wire logic bus_read, // Read level
  input wire logic [23:0] bus_addr, // Byte address
  input wire logic port16, // Target is a word device
  input wire logic ack_on, // Answer with external acks
  input wire logic [3:0] ack_dly, // Clocks from strobe to ack
  output logic [15:0] data_in, // Data pins seen by the unit
  output logic ack_high_n, // Upper ack, active low
  output logic ack_low_n // Lower ack, active low
);
  logic [15:0] last = 16'h0000;
  logic [4:0] cnt = 5'h00;
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Word device: even byte high, odd low; byte device uses only the upper lane
  assign data_in = (!as_n && bus_read) ? (port16 ?
    {pat({bus_addr[23:1], 1'b0}), pat({bus_addr[23:1], 1'b1})} :
    {pat(bus_addr), ~last[7:0]}) : ~last;
  // Strobe age lets acks come late, so a unit that ends early is caught
  always_ff @(posedge clk) begin
    last <= data_in;
    cnt <= as_n ? 5'h00 : cnt + 5'h01;
  end
  // Acks are released to the pull-up level once the strobe goes
  assign ack_high_n = !(ack_on && !as_n && cnt >= {1'b0, ack_dly});
  assign ack_low_n = ack_high_n;
endmodule

// ### verification/chip_select_wait_state_unit_bench.sv
// Purpose: Self-checking bench for the chip-select and wait-state unit
// Assumes: One 25 MHz clock; configuration driven as plain ports
// Notes: Cycle lengths are counted in falling edges after the start edge
`timescale 1ns/1ps
module chip_select_wait_state_unit_bench import cs_unit_pkg::*;;
  logic clk, rstn, cyc_start, cyc_read, cyc_word, cyc_cpu_space, cyc_done, cyc_autovec;
  logic [23:0] cyc_addr, bus_addr, a;
  logic [15:0] cyc_wdata, cyc_rdata, data_out, data_in, w;
  logic [NUM_CS*24-1:0] cs_base, cs_mask;
  logic [NUM_CS-1:0] cs_enable, cs_pin_sel, cs_port16, cs_use_ds, select_n;
  logic [2*NUM_CS-1:0] cs_func, cs_byte, cs_rw;
  logic [4*NUM_CS-1:0] cs_wait;
  logic boot_program, interrupt_ack_strobe, bus_read, as_n, ds_n, data_oe, strap, boot_port16;
  logic ack_h_n, ack_l_n, p16, ack_on, strobe_seen, autovector_termination_seen;
  logic [3:0] ack_dly;
  int n_mismatch = 0, num_checks = 0, lat, f0, fds;
  int first[NUM_CS];
  logic [15:0] wq[$];
  chip_select_wait_state_unit uut (.clk(clk), .rstn(rstn), .cyc_start(cyc_start),
    .cyc_addr(cyc_addr), .cyc_read(cyc_read), .cyc_word(cyc_word),
    .cyc_cpu_space(cyc_cpu_space), .cyc_wdata(cyc_wdata), .cyc_done(cyc_done),
    .cyc_autovec(cyc_autovec), .cyc_rdata(cyc_rdata), .cs_base(cs_base), .cs_mask(cs_mask),
    .cs_enable(cs_enable), .cs_pin_sel(cs_pin_sel), .cs_func(cs_func), .cs_wait(cs_wait),
    .cs_port16(cs_port16), .cs_byte(cs_byte), .cs_rw(cs_rw), .cs_use_ds(cs_use_ds),
    .boot_program(boot_program), .select_n(select_n),
    .interrupt_ack_strobe(interrupt_ack_strobe), .bus_addr(bus_addr), .bus_read(bus_read),
    .as_n(as_n), .ds_n(ds_n), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .width_strap_line(strap), .transfer_size_ack_high_n(ack_h_n),
    .transfer_size_ack_low_n(ack_l_n), .boot_port16(boot_port16));
  ext_mem_model mem (.clk(clk), .as_n(as_n), .bus_read(bus_read), .bus_addr(bus_addr),
    .port16(p16), .ack_on(ack_on), .ack_dly(ack_dly), .data_in(data_in),
    .ack_high_n(ack_h_n), .ack_low_n(ack_l_n));
  // Free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Expected memory contents, kept apart from the partner's copy
  function automatic logic [7:0] eb(input logic [23:0] x);
    return x[15:8] ^ x[7:0] ^ 8'h3C;
  endfunction
  function automatic logic [23:0] ra(input logic [23:0] base);
    return base | (24'($urandom) & 24'h00FFFE);
  endfunction
  task automatic chk_n(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cfg(input int ch, input logic [23:0] b, input logic pw, input logic [3:0] ws,
      input logic [1:0] by, input logic [1:0] rw, input logic [1:0] fn, input logic ds,
      input logic pin);
    @(posedge clk);
    cs_base[ch*24 +: 24] <= b;
    cs_mask[ch*24 +: 24] <= fn == FUNC_SEL ? 24'hFF0000 : 24'hFFFFF0;
    cs_enable[ch] <= 1'b1;
    cs_port16[ch] <= pw;
    cs_wait[ch*4 +: 4] <= ws;
    cs_byte[ch*2 +: 2] <= by;
    cs_rw[ch*2 +: 2] <= rw;
    cs_func[ch*2 +: 2] <= fn;
    cs_use_ds[ch] <= ds;
    cs_pin_sel[ch] <= pin;
  endtask
  // One bus cycle; watches selects, strobe and written lanes until done
  task automatic run(input logic [23:0] ad, input logic rd, input logic wd, input logic cs);
    int n;
    logic po;
    logic [23:0] pa;
    logic [15:0] pd;
    n = 0;
    po = 1'b0;
    wq.delete();
    strobe_seen = 1'b0;
    fds = -1;
    for (int i = 0; i < NUM_CS; i++) first[i] = -1;
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_addr <= ad;
    cyc_read <= rd;
    cyc_word <= wd;
    cyc_cpu_space <= cs;
    cyc_wdata <= w;
    @(posedge clk);
    cyc_start <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      for (int i = 0; i < NUM_CS; i++) if (select_n[i] === 1'b0 && first[i] < 0) first[i] = n;
      if (ds_n === 1'b0 && fds < 0) fds = n;
      if (po && (data_oe !== 1'b1 || bus_addr !== pa)) wq.push_back(pd);
      po = data_oe === 1'b1;
      pa = bus_addr;
      pd = data_out;
      if (interrupt_ack_strobe === 1'b1) strobe_seen = 1'b1;
    end while (cyc_done !== 1'b1 && n < 200);
    if (po) wq.push_back(pd);
    lat = n;
    autovector_termination_seen = cyc_autovec;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: the whole run needs well under a thousand clocks
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h277b));
    {rstn, cyc_start, cyc_read, cyc_word, cyc_cpu_space, boot_program, ack_on} = '0;
    {cyc_addr, cyc_wdata, cs_base, cs_mask, cs_enable, cs_pin_sel, cs_port16} = '0;
    {cs_use_ds, cs_func, cs_byte, cs_rw, cs_wait, ack_dly, w} = '0;
    strap = 1'b1;
    p16 = 1'b1;
    repeat (3) @(posedge clk);
    chk_v({4'h0, select_n}, 16'h0FFF, "selects in reset");
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_v({15'h0, boot_port16}, 16'h0001, "boot width");
    a = ra(24'h000000);
    run(a, 1'b1, 1'b1, 1'b0);
    chk_n(lat, 3 + 13 + 1, "boot length");
    chk_v(cyc_rdata, {eb(a), eb(a | 24'h1)}, "boot word");
    w = 16'($urandom);
    run(a | 24'h1, 1'b0, 1'b0, 1'b0);
    chk_v(wq[0], w, "boot whole word");
    @(posedge clk);
    boot_program <= 1'b1;
    for (int ws = 0; ws <= 14; ws++) begin
      cfg(1, 24'h010000, 1'b1, 4'(ws), BYTE_BOTH, RW_BOTH, FUNC_SEL, 1'b0, 1'b1);
      a = ra(24'h010000);
      run(a, 1'b1, 1'b1, 1'b0);
      chk_n(lat, ws == 14 ? 3 : 4 + ws, "wait length");
      // A fast read ends before the data synchroniser holds strobed data
      if (ws < 14) begin
        chk_v(cyc_rdata, {eb(a), eb(a | 24'h1)}, "word read");
        run(a | 24'(ws & 1), 1'b1, 1'b0, 1'b0);
        chk_v(cyc_rdata, {8'h00, eb(a | 24'(ws & 1))}, "byte lane");
      end
    end
    w = 16'($urandom);
    run(a, 1'b0, 1'b0, 1'b0);
    f0 = first[1];
    cfg(1, 24'h010000, 1'b1, 4'h0, BYTE_BOTH, RW_BOTH, FUNC_SEL, 1'b1, 1'b1);
    run(a, 1'b0, 1'b0, 1'b0);
    chk_n(first[1], f0 + 1, "ds write select");
    chk_n(fds, 2, "ds write strobe");
    run(a, 1'b1, 1'b0, 1'b0);
    chk_n(first[1], f0, "ds read select");
    chk_n(fds, 1, "ds read strobe");
    p16 = 1'b0;
    cfg(2, 24'h020000, 1'b0, 4'h0, BYTE_BOTH, RW_BOTH, FUNC_SEL, 1'b0, 1'b1);
    a = ra(24'h020000);
    run(a, 1'b0, 1'b1, 1'b0);
    chk_n(lat, 7, "split write");
    chk_n(wq.size(), 2, "write halves");
    chk_v(wq[0], {2{w[15:8]}}, "even half");
    chk_v(wq[1], {2{w[7:0]}}, "odd half");
    run(a, 1'b1, 1'b1, 1'b0);
    chk_v(cyc_rdata, {eb(a), eb(a | 24'h1)}, "split read");
    run(a | 24'h1, 1'b1, 1'b0, 1'b0);
    chk_v(cyc_rdata, {8'h00, eb(a | 24'h1)}, "byte port read");
    p16 = 1'b1;
    cfg(3, 24'h030000, 1'b1, 4'h1, BYTE_UPPER, RW_BOTH, FUNC_SEL, 1'b0, 1'b1);
    cfg(4, 24'h030000, 1'b1, 4'h1, BYTE_LOWER, RW_BOTH, FUNC_SEL, 1'b0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      run(ra(24'h030000) | 24'(k == 1), 1'b1, k == 2, 1'b0);
      chk_n(lat, 5, "lane length");
      chk_n(first[3] > 0, k != 1, "upper decode");
      chk_n(first[4] > 0, k != 0, "lower decode");
    end
    cfg(5, 24'h040000, 1'b1, 4'h0, BYTE_BOTH, RW_READ, FUNC_SEL, 1'b0, 1'b1);
    cfg(9, 24'h040000, 1'b1, 4'h0, BYTE_BOTH, RW_WRITE, FUNC_SEL, 1'b0, 1'b1);
    for (int rd = 0; rd < 2; rd++) begin
      run(ra(24'h040000), rd == 1, 1'b1, 1'b0);
      chk_n(first[5] > 0, rd, "read only");
      chk_n(first[9] > 0, 1 - rd, "write only");
    end
    cfg(6, 24'h050000, 1'b1, WAIT_EXT, BYTE_BOTH, RW_BOTH, FUNC_SEL, 1'b0, 1'b1);
    ack_on <= 1'b1;
    for (int d = 2; d < 12; d += 7) begin
      ack_dly <= 4'(d);
      run(ra(24'h050000), 1'b1, 1'b1, 1'b0);
      chk_n(lat >= d + 3 && lat <= d + 6, 1, "external ack");
    end
    ack_on <= 1'b0;
    cfg(7, 24'h060000, 1'b1, 4'h2, BYTE_BOTH, RW_BOTH, FUNC_SEL, 1'b0, 1'b0);
    run(ra(24'h060000), 1'b1, 1'b1, 1'b0);
    chk_n(lat, 6, "pin reassigned");
    chk_n(first[7], -1, "pin kept high");
    cfg(8, 24'hFFFFF0, 1'b1, 4'h0, BYTE_BOTH, RW_BOTH, FUNC_AUTOVECTOR_TERMINATION, 1'b0, 1'b1);
    cfg(10, 24'hFFFFE0, 1'b1, 4'h0, BYTE_BOTH, RW_BOTH, FUNC_INTERRUPT_ACK_STROBE, 1'b0, 1'b1);
    run(24'hFFFFF2, 1'b1, 1'b0, 1'b1);
    chk_v({15'h0, autovector_termination_seen}, 16'h0001, "autovector");
    run(24'hFFFFE4, 1'b1, 1'b0, 1'b1);
    chk_v({14'h0, autovector_termination_seen, strobe_seen}, 16'h0001, "interrupt_ack_strobe strobe");
    @(posedge clk);
    rstn <= 1'b0;
    strap <= 1'b0;
    boot_program <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_v({15'h0, boot_port16}, 16'h0000, "strap low");
    p16 = 1'b0;
    a = ra(24'h000000);
    run(a, 1'b1, 1'b1, 1'b0);
    chk_n(lat, 33, "boot byte port");
    chk_v(cyc_rdata, {eb(a), eb(a | 24'h1)}, "boot split read");
    end_of_test();
  end
endmodule
